// >>> dv/dsq_dram_model.sv
// Behavioural DRAM array that answers the sequencer's strobes.
`timescale 1ns/1ps
module dsq_dram_model
  import dsq_pkg::*;
(
  // Clock and part type.
  input wire logic clk_sys,
  input wire logic edo,
  // Strobes in, read data out.
  input wire dsq_pkg::dsq_pins_t pins,
  output logic [31:0] dq_i
);
  logic [31:0] mem [0:4095];
  logic [3:0] row;
  logic [11:0] ix;
  logic pr = 1'b1;
  logic was_on = 1'b0;
  logic cas_on;
  logic [31:0] junk = 32'h5a5a_0f0f;
  assign cas_on = pins.cas_n != 4'hf;
  // Data holds one cycle past the strobe unless EDO; stale reads see a toggling pattern.
  assign dq_i = (cas_on || was_on || (edo && !pins.ras_n)) ?
    mem[cas_on ? {row, pins.addr[9:2]} : ix] : junk;
  // Row on the strobe fall; column and lane writes while a column strobe is low.
  always @(posedge clk_sys) begin
    pr <= pins.ras_n;
    was_on <= cas_on;
    junk <= ~dq_i;
    if (pr && !pins.ras_n) row <= pins.addr[3:0];
    if (cas_on) begin
      ix <= {row, pins.addr[9:2]};
      for (int i = 0; i < 4; i++) begin
        if (!pins.cas_n[i] && !pins.rdwr)
          mem[{row, pins.addr[9:2]}][8*i +: 8] <= pins.dq_en_n ? junk[8*i +: 8] :
            pins.dq_o[8*i +: 8];
      end
    end
  end
endmodule

// >>> dv/dsq_sequencer_assertions.sv
// Port-level checks for the DRAM access sequencer.
`timescale 1ns/1ps
module dsq_checks
  import dsq_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Request side and DRAM pins.
  input wire logic req_take,
  input wire dsq_pkg::dsq_req_t req,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire dsq_pkg::dsq_pins_t pins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [9:0] top;
  logic cas_on;
  // The upper pins must echo the taken address, so keep its top bits.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      top <= 10'h000;
    end else if (req_take) begin
      top <= req.addr[25:16];
    end
  end
  // Any lane strobe low counts as a column phase.
  assign cas_on = pins.cas_n != 4'hf;
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack too long");
  AST_UPPER: assert property (cas_on |-> pins.addr[25:16] == top)
    else $error("upper address pins differ");
  AST_RAS_CAS: assert property (cas_on |-> !pins.ras_n)
    else $error("column strobe without row strobe");
  AST_CS_ONE: assert property (cas_on |-> pins.cs_a_n != pins.cs_b_n)
    else $error("area select wrong in column phase");
  AST_CS_RAS: assert property (!(pins.cs_a_n && pins.cs_b_n) |-> !pins.ras_n)
    else $error("area select outside access");
  AST_RSP_WIN: assert property (req_take |=> !rsp_valid ##[0:40] rsp_valid)
    else $error("response outside window");
  AST_LAST: assert property (rsp_last |-> rsp_valid)
    else $error("last flag without response");
  AST_DACK: assert property (pins.dack |-> pins.cas_n == 4'hf)
    else $error("acknowledge outside idle cycle");
  COV_WRITE: cover property (req_take && req.we);
  COV_BURST: cover property (rsp_valid ##1 rsp_valid);
  COV_DACK: cover property (pins.dack);
endmodule
bind dsq_sequencer dsq_checks u_chk (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .req_take(req_take), .req(req),
  .rsp_valid(rsp_valid), .rsp_last(rsp_last), .pins(pins));

// >>> dv/testbench.sv
// Self-checking bench for the DRAM access sequencer.
`timescale 1ns/1ps
module testbench;
  import dsq_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, req_valid = 1'b0, edo = 1'b0;
  logic wait_n = 1'b1;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, req_wdata = 32'h0, wb_dat_o, rsp_rdata, dq_i, q;
  logic wb_ack_o, req_take, rsp_valid, rsp_last, pr = 1'b1, pc = 1'b0;
  dsq_req_t req = '0;
  dsq_pins_t pins;
  logic [25:0] row_s, col_s;
  logic [1:0] cs_s;
  logic [31:0] rd [4];
  logic [31:0] ms [4] = '{32'h1ff, 32'h7, 32'h3f, 32'h0};
  logic [31:0] km [4] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h7};
  int n_errors = 0, n_tests = 0, cyc = 0, n_ras = 0, n_cas = 0, n_dack = 0;
  int t_ras = 0, t_up = 0, rc = 0, hi = 0, lat, fst, s_ras, s_cas, s_dack;
  localparam logic [25:0] A = 26'h2b5_c3a4;
  always #10 clk_sys = ~clk_sys;
  dsq_sequencer DUT (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid, .req, .req_wdata, .req_take, .rsp_valid,
    .rsp_last, .rsp_rdata, .wait_n, .dq_i, .pins);
  dsq_dram_model u_mem (.clk_sys, .edo, .pins, .dq_i);
  // Pin monitor; non-blocking so the sequence reads settled counts. Also cuts a hang.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    pr <= pins.ras_n;
    pc <= pins.cas_n != 4'hf;
    if (pins.cas_n != 4'hf) n_cas <= n_cas + 1;
    if (pins.dack) n_dack <= n_dack + 1;
    if (!pr && pins.ras_n) t_up <= cyc;
    if (pr && !pins.ras_n) begin
      n_ras <= n_ras + 1;
      row_s <= pins.addr;
      t_ras <= cyc;
      hi <= cyc - t_up;
    end
    if (!pc && pins.cas_n != 4'hf) begin
      col_s <= pins.addr;
      cs_s <= {pins.cs_b_n, pins.cs_a_n};
      rc <= cyc - t_ras;
    end
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; the request stands until ack is sampled high.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic cfg(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
    bus(1'b1, OFS_CTRL_A, a);
    bus(1'b1, OFS_CTRL_B, b);
    bus(1'b1, OFS_MODE, m);
    edo <= m[MD_EDO];
  endtask
  // One request held until taken; beats collected until the last response.
  task automatic acc(input logic [25:0] a, input logic w, input logic [3:0] be,
    input logic ar, input logic dm, input logic [1:0] n, input logic [31:0] d);
    int k;
    k = 0;
    req_valid <= 1'b1;
    req <= '{addr: a, we: w, area: ar, be: be, dma: dm, beats: n};
    req_wdata <= d;
    s_ras = n_ras;
    s_cas = n_cas;
    s_dack = n_dack;
    do @(posedge clk_sys); while (req_take !== 1'b1);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
      if (rsp_valid === 1'b1) begin
        rd[k] = rsp_rdata;
        k++;
        if (k == 1) fst = lat;
      end
    end while (rsp_valid !== 1'b1 || rsp_last !== 1'b1);
  endtask
  function automatic logic [15:0] rowx(input logic [25:0] a, input int m);
    logic [15:0] r;
    for (int k = 0; k < 16; k++) r[k] = (k + 9 + m <= 25) ? a[k + 9 + m] : a[k];
    return r;
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'(i * 4), 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 4'(i * 4), 32'hffff_ffff);
      bus(1'b0, 4'(i * 4), 32'h0);
      chk(q & km[i], ms[i]);
    end
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("registers done");
    cfg(32'h0, 32'h0, 32'h0);
    acc(26'h100, 1'b1, 4'hf, 1'b0, 1'b0, 2'h0, 32'h1234_5678);
    chk(lat, 4);
    chk(n_cas - s_cas, 1);
    acc(26'h100, 1'b1, 4'h3, 1'b0, 1'b0, 2'h0, 32'hcafe_beef);
    acc(26'h100, 1'b0, 4'hf, 1'b0, 1'b0, 2'h0, 32'h0);
    chk(lat, 4);
    chk(rd[0], 32'h1234_beef);
    for (int m = 0; m < 8; m++) begin
      cfg(32'h0, 32'h0, 32'(m));
      acc(A, 1'b0, 4'hf, m[0], 1'b0, 2'h0, 32'h0);
      chk(32'(row_s), {6'h0, A[25:16], rowx(A, m)});
      chk(32'(col_s), 32'(A));
      chk(32'(cs_s), m[0] ? 32'h1 : 32'h2);
    end
    $display("basic and multiplexing done");
    for (int i = 0; i < 4; i++) begin
      cfg(32'({i[1:0], i[1:0], i[1:0], 1'b1, i[1:0]}), 32'(i[0]), 32'h0);
      acc(26'h200, 1'b1, 4'hf, 1'b0, 1'b0, 2'h0, 32'h0bad_f00d);
      chk(lat, 5 + 3 * i + i % 2);
      chk(rc, 2 * i + 2);
      chk(n_cas - s_cas, 1 + i % 2);
      acc(26'h200, 1'b0, 4'hf, 1'b0, 1'b0, 2'h0, 32'h0);
      chk(lat, 5 + 3 * i);
      chk(hi, i + 2);
    end
    $display("timing done");
    // Wait held low through set-up, released six edges after it; filter adds four.
    wait_n <= 1'b0;
    cfg(32'h0, 32'h4, 32'h0);
    fork
      begin
        repeat (6) @(posedge clk_sys);
        wait_n <= 1'b1;
      end
    join_none
    acc(26'h100, 1'b0, 4'hf, 1'b0, 1'b0, 2'h0, 32'h0);
    chk(lat, 12);
    $display("wait done");
    cfg(32'h0, 32'h0, 32'h8);
    for (int b = 0; b < 4; b++) acc(26'(12'h300 + 4 * b), 1'b1, 4'hf, 1'b0, 1'b0, 2'h0, 32'(b));
    acc(26'h300, 1'b0, 4'hf, 1'b0, 1'b0, 2'h3, 32'h0);
    chk(n_ras - s_ras, 1);
    for (int b = 0; b < 4; b++) chk(rd[b], 32'(b));
    cfg(32'h0, 32'h0, 32'h28);
    acc(26'h300, 1'b0, 4'hf, 1'b0, 1'b0, 2'h3, 32'h0);
    chk(lat - fst, 3);
    for (int b = 0; b < 4; b++) chk(rd[b], 32'(b));
    cfg(32'h0, 32'h0, 32'h0);
    acc(26'h300, 1'b0, 4'hf, 1'b0, 1'b0, 2'h3, 32'h0);
    chk(n_ras - s_ras, 4);
    $display("burst done");
    cfg(32'h2, 32'h2, 32'h18);
    acc(26'h400, 1'b0, 4'hf, 1'b0, 1'b0, 2'h0, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({pins.ras_n, pins.cs_a_n}, 2'b01);
    acc(26'h408, 1'b0, 4'hf, 1'b0, 1'b1, 2'h0, 32'h0);
    chk(n_ras - s_ras, 0);
    chk(n_dack - s_dack, 1);
    acc(26'h100400, 1'b0, 4'hf, 1'b0, 1'b0, 2'h0, 32'h0);
    chk(n_ras - s_ras, 1);
    chk(hi, 3);
    cfg(32'h0, 32'h0, 32'h8);
    acc(26'h400, 1'b0, 4'hf, 1'b0, 1'b0, 2'h0, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(pins.ras_n, 1'b1);
    $display("row hold done");
    print_verdict();
  end
endmodule

// >>> logic/dsq_pkg.sv
// Shared constants and carrier types for the DRAM access sequencer.
package dsq_pkg;
  localparam int ADDR_W = 26;
  localparam int MUX_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int COL_BASE = 9;
  localparam logic [25:0] BEAT_STEP = 26'h0000004;
  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // Field positions of dram_timing_ctrl_a.
  localparam int CA_TPC = 0;
  localparam int CA_RCD = 2;
  localparam int CA_DWR = 5;
  localparam int CA_DWW = 7;
  // Field positions of dram_timing_ctrl_b and dram_mode_ctrl.
  localparam int CB_WRITE_COL_WIDTH = 0;
  localparam int CB_IDLE = 1;
  localparam int CB_WAIT = 2;
  localparam int MD_MUX = 0;
  localparam int MD_BURST = 3;
  localparam int MD_HOLD = 4;
  localparam int MD_EDO = 5;
  localparam logic [8:0] RST_CTRL_A = 9'h000;
  localparam logic [2:0] RST_CTRL_B = 3'h0;
  localparam logic [5:0] RST_MODE = 6'h00;
  // Column phase lengths in cycles.
  localparam logic [2:0] LEN_BASE = 3'h2;
  localparam logic [2:0] LEN_EDO = 3'h1;
  localparam logic [2:0] LEN_EDO_SLOW = 3'h2;

  typedef enum logic [2:0] {
    DSQ_IDLE = 3'b000,
    DSQ_PRECH = 3'b001,
    DSQ_ROW = 3'b010,
    DSQ_RCD = 3'b011,
    DSQ_COL = 3'b100,
    DSQ_COLX = 3'b101,
    DSQ_DIDLE = 3'b110,
    DSQ_OPEN = 3'b111
  } dsq_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic we;
    logic area;
    logic [LANES-1:0] be;
    logic dma;
    logic [1:0] beats;
  } dsq_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ras_n;
    logic [LANES-1:0] cas_n;
    logic rdwr;
    logic cs_a_n;
    logic cs_b_n;
    logic dack;
    logic dq_en_n;
    logic [DATA_W-1:0] dq_o;
  } dsq_pins_t;
endpackage

// >>> logic/dsq_sequencer.sv
// DRAM access sequencer: Wishbone register file, access state machine and pin drive.
//
// Function
// - Low sixteen address pins multiplexed row/column; upper pins carry original bits.
// - Three-bit select picks column width nine through sixteen bits.
// - Column phase passes bits 0-15; row phase shifts down, overflow keeps column bits.
// - Basic access is row cycle, column cycle, read latch cycle.
// - One to four precharge cycles from timing register A.
// - Row-to-column delay one to eight cycles.
// - Read column phase two to five cycles; EDO fixes one on consecutive columns, two otherwise.
// - Write column phase two to five cycles; EDO fixes one.
// - Write column strobe width one or two; two adds one end cycle.
// - Wait input sampled in column cycle stretches access while low.
// - Fast page drives row once then columns; otherwise row every access.
// - Burst when access wider than bus or DMA single-address burst.
// - EDO select switches reads to extended-data-out timing.
// - EDO one-cycle reads only for consecutive columns.
// - Row strobe up mode closes row between other-space accesses.
// - Burst plus hold bit keeps row open; same row continues burst.
// - Idle cycle with DMA acknowledge before same-row DMA single burst.
// - Area chip select asserted for whole access.
// - One column strobe per byte lane.
`timescale 1ns/1ps
module dsq_sequencer
  import dsq_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Wishbone register slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Internal bus request side.
  input wire logic req_valid,
  input wire dsq_pkg::dsq_req_t req,
  input wire logic [dsq_pkg::DATA_W-1:0] req_wdata,
  output logic req_take,
  output logic rsp_valid,
  output logic rsp_last,
  output logic [dsq_pkg::DATA_W-1:0] rsp_rdata,
  // DRAM pins.
  input wire logic wait_n,
  input wire logic [dsq_pkg::DATA_W-1:0] dq_i,
  output dsq_pkg::dsq_pins_t pins
);
  import dsq_pkg::*;

  typedef struct packed {
    dsq_state_t state;
    logic [2:0] cnt;
    logic cas2;
    logic reopen;
    logic consec;
    logic [1:0] beats;
    dsq_req_t cur;
    logic [ADDR_W-1:0] open_addr;
    logic open_area;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rsp;
    logic last;
    logic [8:0] ctrl_a;
    logic [2:0] ctrl_b;
    logic [5:0] mode;
    logic ack;
    logic [31:0] rdat;
    logic w1;
    logic w2;
    logic w3;
    logic wait_f;
  } dsq_st_t;

  dsq_st_t st;
  dsq_st_t next_st;

  // Row-phase pin pattern: address shifted by column width, high pins keep column bits.
  function automatic logic [MUX_W-1:0] row_pins(input logic [ADDR_W-1:0] a,
                                                input logic [2:0] mw);
    logic [ADDR_W-1:0] sh;
    logic [MUX_W-1:0] r;
    sh = a >> (COL_BASE + int'(mw));
    for (int i = 0; i < MUX_W; i++) begin
      r[i] = (i + COL_BASE + int'(mw) < ADDR_W) ? sh[i] : a[i];
    end
    return r;
  endfunction

  // Row identity used to detect a page hit.
  function automatic logic [ADDR_W-1:0] row_key(input logic [ADDR_W-1:0] a,
                                                input logic [2:0] mw);
    return a >> (COL_BASE + int'(mw));
  endfunction

  logic [2:0] mw;
  logic burst_en;
  logic hold_en;
  logic edo;
  logic [2:0] col_len;
  logic row_hit;

  // Column phase length; EDO reads only reach one cycle on consecutive columns.
  always_comb begin
    mw = st.mode[MD_MUX +: 3];
    burst_en = st.mode[MD_BURST];
    hold_en = st.mode[MD_BURST] & st.mode[MD_HOLD];
    edo = st.mode[MD_EDO];
    if (st.cur.we) begin
      col_len = edo ? LEN_EDO : LEN_BASE + {1'b0, st.ctrl_a[CA_DWW +: 2]};
      col_len = col_len + {2'b00, st.ctrl_b[CB_WRITE_COL_WIDTH]};
    end else if (edo) begin
      col_len = st.consec ? LEN_EDO : LEN_EDO_SLOW;
    end else begin
      col_len = LEN_BASE + {1'b0, st.ctrl_a[CA_DWR +: 2]};
    end
    row_hit = (row_key(req.addr, mw) == row_key(st.open_addr, mw)) &&
              (req.area == st.open_area);
  end

  // Next-state logic for the register file, the wait filter and the sequencer.
  always_comb begin
    logic wr;
    wr = 1'b0;
    next_st = st;
    next_st.rsp = 1'b0;
    next_st.last = 1'b0;
    req_take = 1'b0;
    // Wait pin: three flops, a change counts once the last two agree.
    next_st.w1 = wait_n;
    next_st.w2 = st.w1;
    next_st.w3 = st.w2;
    if (st.w2 == st.w3) begin
      next_st.wait_f = st.w3;
    end
    // Classic Wishbone slave; one wait state, unmapped reads return zero.
    // Writes land on the edge that also shows ack, so master and slave agree on it.
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & st.ack;
    if (wr && wb_adr_i == OFS_CTRL_A) begin
      if (wb_sel_i[0]) next_st.ctrl_a[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_st.ctrl_a[8] = wb_dat_i[8];
    end
    if (wr && wb_adr_i == OFS_CTRL_B && wb_sel_i[0]) begin
      next_st.ctrl_b = wb_dat_i[2:0];
    end
    if (wr && wb_adr_i == OFS_MODE && wb_sel_i[0]) begin
      next_st.mode = wb_dat_i[5:0];
    end
    case (wb_adr_i)
      OFS_CTRL_A: next_st.rdat = {23'h000000, st.ctrl_a};
      OFS_CTRL_B: next_st.rdat = {29'h00000000, st.ctrl_b};
      OFS_MODE: next_st.rdat = {26'h0000000, st.mode};
      OFS_STATUS: next_st.rdat = {27'h0000000, st.reopen, st.cas2, st.state};
      default: next_st.rdat = 32'h00000000;
    endcase
    case (st.state)
      DSQ_IDLE: begin
        if (req_valid) begin
          req_take = 1'b1;
          next_st.cur = req;
          next_st.beats = req.beats;
          next_st.wdata = req_wdata;
          next_st.consec = 1'b0;
          next_st.state = DSQ_ROW;
        end
      end
      DSQ_ROW: begin
        next_st.open_addr = st.cur.addr;
        next_st.open_area = st.cur.area;
        next_st.reopen = 1'b0;
        next_st.cnt = st.ctrl_a[CA_RCD +: 3];
        next_st.state = (st.ctrl_a[CA_RCD +: 3] == 3'h0) ? DSQ_COL : DSQ_RCD;
      end
      DSQ_RCD: begin
        next_st.cnt = st.cnt - 3'h1;
        if (st.cnt == 3'h1) begin
          next_st.state = DSQ_COL;
        end
      end
      DSQ_DIDLE: begin
        next_st.state = DSQ_COL;
      end
      DSQ_COL, DSQ_COLX: begin
        if (st.state == DSQ_COL && st.ctrl_b[CB_WAIT] && !st.wait_f) begin
          next_st.state = DSQ_COL;
        end else if (st.state == DSQ_COL && col_len != 3'h1) begin
          next_st.cnt = col_len - 3'h2;
          next_st.cas2 = st.cur.we & st.ctrl_b[CB_WRITE_COL_WIDTH];
          next_st.state = DSQ_COLX;
        end else if (st.state == DSQ_COLX && st.cnt != 3'h0) begin
          next_st.cnt = st.cnt - 3'h1;
          next_st.cas2 = 1'b0;
        end else begin
          // End of one beat: latch read data and decide how the row continues.
          next_st.cas2 = 1'b0;
          next_st.rsp = 1'b1;
          if (!st.cur.we) begin
            next_st.rdata = dq_i;
          end
          next_st.last = (st.beats == 2'h0);
          if (st.beats != 2'h0) begin
            next_st.beats = st.beats - 2'h1;
            next_st.cur.addr = st.cur.addr + BEAT_STEP;
            next_st.wdata = req_wdata;
            next_st.consec = 1'b1;
            next_st.reopen = ~burst_en;
            next_st.state = burst_en ? DSQ_COL : DSQ_PRECH;
          end else begin
            next_st.state = hold_en ? DSQ_OPEN : DSQ_PRECH;
          end
          next_st.cnt = {1'b0, st.ctrl_a[CA_TPC +: 2]};
        end
      end
      DSQ_PRECH: begin
        next_st.cnt = st.cnt - 3'h1;
        if (st.cnt == 3'h0) begin
          next_st.state = st.reopen ? DSQ_ROW : DSQ_IDLE;
        end
      end
      DSQ_OPEN: begin
        next_st.cnt = {1'b0, st.ctrl_a[CA_TPC +: 2]};
        if (!hold_en) begin
          next_st.state = DSQ_PRECH;
        end else if (req_valid) begin
          req_take = 1'b1;
          next_st.cur = req;
          next_st.beats = req.beats;
          next_st.wdata = req_wdata;
          next_st.consec = (req.addr == st.cur.addr + BEAT_STEP);
          if (!row_hit) begin
            next_st.reopen = 1'b1;
            next_st.state = DSQ_PRECH;
          end else if (req.dma && st.ctrl_b[CB_IDLE]) begin
            next_st.state = DSQ_DIDLE;
          end else begin
            next_st.state = DSQ_COL;
          end
        end
      end
      default: begin
        next_st.state = DSQ_IDLE;
      end
    endcase
  end

  // All state lives in one register; every field has a constant reset value.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.state <= DSQ_IDLE;
      st.ctrl_a <= RST_CTRL_A;
      st.ctrl_b <= RST_CTRL_B;
      st.mode <= RST_MODE;
      st.w1 <= 1'b1;
      st.w2 <= 1'b1;
      st.w3 <= 1'b1;
      st.wait_f <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  logic in_access;
  logic row_on;
  logic cas_on;

  // Pin drive decodes registered state only, so pins never glitch on inputs.
  always_comb begin
    in_access = (st.state == DSQ_ROW) || (st.state == DSQ_RCD) ||
                (st.state == DSQ_COL) || (st.state == DSQ_COLX) ||
                (st.state == DSQ_DIDLE);
    row_on = in_access || (st.state == DSQ_OPEN);
    // Reads pulse the strobe once; writes hold it one cycle, or two with the width bit.
    cas_on = (st.state == DSQ_COL) ||
             (st.state == DSQ_COLX && st.cur.we && st.cas2);
    pins.addr[ADDR_W-1:MUX_W] = st.cur.addr[ADDR_W-1:MUX_W];
    if (st.state == DSQ_ROW || st.state == DSQ_RCD) begin
      pins.addr[MUX_W-1:0] = row_pins(st.cur.addr, mw);
    end else begin
      pins.addr[MUX_W-1:0] = st.cur.addr[MUX_W-1:0];
    end
    pins.ras_n = ~row_on;
    pins.cas_n = cas_on ? ~st.cur.be : {LANES{1'b1}};
    pins.rdwr = ~(in_access && st.cur.we);
    pins.cs_a_n = ~(in_access && !st.cur.area);
    pins.cs_b_n = ~(in_access && st.cur.area);
    pins.dack = (st.state == DSQ_DIDLE);
    pins.dq_en_n = ~(in_access && st.cur.we && st.state != DSQ_ROW);
    pins.dq_o = st.wdata;
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign rsp_valid = st.rsp;
  assign rsp_last = st.last;
  assign rsp_rdata = st.rdata;
endmodule
